/* rtl/pixel_clock_monitor.sv */
`timescale 1ns/10ps
module pixel_clock_monitor
  import pixel_link_pkg::*;
#(
  parameter int GAP_W = 16
)
(
  // clock and reset
  input  wire logic clock_in,
  input  wire logic sys_rst_in,
  // pixel clock pin
  input  wire logic pixel_clk_in,
  // status toward the serializer
  output logic      pixel_edge_out,
  output logic      clock_stopped_out
);

  logic             sync1_q;
  logic             sync2_q;
  logic             sync3_q;
  logic [GAP_W-1:0] gap_q;
  logic [GAP_W-1:0] gap_d;
  logic [GAP_W-1:0] period_q;
  logic [GAP_W-1:0] period_d;
  logic             stopped_q;
  logic             stopped_d;
  logic [GAP_W+2:0] stop_limit;
  logic             edge_seen;

  ////////////////////////////////////////////////////////////////////////////
  // gap is measured against the last period, so any pixel period up to a quarter of the GAP_W-bit gap count works
  always_comb
  begin
    edge_seen  = sync2_q & ~sync3_q;
    stop_limit = (GAP_W+3)'(period_q) * (GAP_W+3)'(STOP_PIXELS);
    gap_d      = gap_q;
    period_d   = period_q;
    stopped_d  = stopped_q;
    if (edge_seen)
    begin
      gap_d     = '0;
      period_d  = (gap_q == '1) ? gap_q : GAP_W'(gap_q + 1'b1);
      stopped_d = 1'b0;
    end
    else
    begin
      if (gap_q != '1)
        gap_d = GAP_W'(gap_q + 1'b1);
      if ({3'b000, gap_q} >= stop_limit)
        stopped_d = 1'b1;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      sync1_q   <= 1'b0;
      sync2_q   <= 1'b0;
      sync3_q   <= 1'b0;
      gap_q     <= '0;
      period_q  <= '0;
      stopped_q <= 1'b1;
    end
    else
    begin
      sync1_q   <= pixel_clk_in;
      sync2_q   <= sync1_q;
      sync3_q   <= sync2_q;
      gap_q     <= gap_d;
      period_q  <= period_d;
      stopped_q <= stopped_d;
    end
  end

  assign pixel_edge_out    = edge_seen;
  assign clock_stopped_out = stopped_q;

endmodule // pixel_clock_monitor

/* rtl/rgb_pixel_link_serializer.sv */
`timescale 1ns/10ps
// Behaviour
// - 24-bit mode, no dither: full 24-bit colour, link clock 8x pixel
// - dither mode: 24-bit colour reduced to 18 bits, link clock 6x
// - 18-bit mode, no dither: 18-bit colour sent directly, link clock 6x
// - after reset: 18-bit input, dither off, 6x clock
// - bit period is pixel/12 in 18-bit mode, pixel/16 in 24-bit mode
// - pixel clock stopped four periods or more resets the device
// - after a stop, wait for lock and start-up before any video
// - colour, vsync, hsync, valid over two data lanes and a clock lane
// - data bits sampled on both link clock edges
// - phases off, start-up, active with only the legal transitions
// - off phase drives every link output to ground
// - enabled but unlocked: all link outputs held at static level
// - on lock the clock lane toggles and payloads stream, phase active
// - inputs captured each pixel rising edge, sent pixel by pixel
// - payload: colour, vsync, hsync, valid, parity, sequence; 32 or 24 bits
// - parity makes the ones count odd over colour, control, sequence
// - two-bit sequence counter steps by one per payload, modulo four
module rgb_pixel_link_serializer
  import pixel_link_pkg::*;
#(
  parameter int BIT_DIV     = BIT_DIV_DEF,
  parameter int LOCK_PIXELS = LOCK_PIXELS_DEF
)
(
  // clock and reset
  input  wire logic                clock_in,
  input  wire logic                sys_rst_in,
  // pixel bus
  input  wire logic                pixel_clk_in,
  input  wire logic [COLOR_W-1:0]  color_in,
  input  wire logic                vertical_sync_in,
  input  wire logic                horizontal_sync_in,
  input  wire logic                pixel_valid_in,
  // configuration straps
  input  wire logic                width_24_in,
  input  wire logic                dither_en_in,
  // serial link
  output logic                     link_clock_lane_p_out,
  output logic                     link_clock_lane_n_out,
  output logic [LANE_CNT-1:0]      link_data_lane_p_out,
  output logic [LANE_CNT-1:0]      link_data_lane_n_out,
  // status
  output logic [1:0]               link_phase_out
);

  localparam int IN_W   = COLOR_W + 3;
  localparam int DIV_W  = $clog2(BIT_DIV);
  localparam int LOCK_W = $clog2(LOCK_PIXELS + 1);
  localparam logic [DIV_W-1:0]  DIV_LAST  = DIV_W'(BIT_DIV - 1);
  // clock toggles one slot before the middle of the bit, so that the
  // registered clock edge lands mid-bit, except on a pixel load at DIV_HALF, which changes clock and data together
  localparam logic [DIV_W-1:0]  DIV_HALF  = DIV_W'(BIT_DIV / 2 - 1);
  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_PIXELS - 1);

  function automatic logic [5:0] round_to_6(input logic [7:0] ch);
    logic [6:0] sum;
    sum = {1'b0, ch[7:2]} + {6'h00, ch[1]};
    round_to_6 = sum[6] ? 6'h3f : sum[5:0];
  endfunction

  function automatic logic [PAYLOAD_W-1:0] build_payload(
    input mode_t              mode,
    input logic [COLOR_W-1:0] c,
    input logic               vs,
    input logic               hs,
    input logic               pv,
    input logic [1:0]         fs
  );
    logic [17:0] c18;
    logic        par;
    c18 = {c[23:18], c[15:10], c[7:2]};
    if (mode == MODE_DITHER)
      c18 = {round_to_6(c[23:16]), round_to_6(c[15:8]), round_to_6(c[7:0])};
    if (mode == MODE_24)
    begin
      par = ~(^c ^ vs ^ hs ^ pv ^ ^fs);
      build_payload = {c, vs, hs, pv, par, fs, RESERVED_BITS};
    end
    else
    begin
      par = ~(^c18 ^ vs ^ hs ^ pv ^ ^fs);
      build_payload = {c18, vs, hs, pv, par, fs, PAD_18};
    end
  endfunction

  logic [IN_W-1:0]      in1_q;
  logic [IN_W-1:0]      in2_q;
  logic [IN_W-1:0]      in3_q;
  logic [1:0]           cfg1_q;
  logic [1:0]           cfg2_q;
  logic                 pixel_edge;
  logic                 clock_stopped;
  phase_t               phase_q;
  phase_t               phase_d;
  mode_t                mode_q;
  mode_t                mode_d;
  mode_t                mode_req;
  logic [LOCK_W-1:0]    lock_q;
  logic [LOCK_W-1:0]    lock_d;
  logic [1:0]           fseq_q;
  logic [1:0]           fseq_d;
  logic [PAYLOAD_W-1:0] shift_q;
  logic [PAYLOAD_W-1:0] shift_d;
  logic [PAYLOAD_W-1:0] payload;
  logic [4:0]           bits_left_q;
  logic [4:0]           bits_left_d;
  logic [DIV_W-1:0]     div_q;
  logic [DIV_W-1:0]     div_d;
  logic                 clk_lvl_q;
  logic                 clk_lvl_d;
  logic [LANE_CNT-1:0]  bit_q;
  logic [LANE_CNT-1:0]  bit_d;
  logic                 load;
  logic                 lock_done;
  logic                 clk_p_d;
  logic                 clk_n_d;
  logic [LANE_CNT-1:0]  dat_p_d;
  logic [LANE_CNT-1:0]  dat_n_d;

  ////////////////////////////////////////////////////////////////////////////
  pixel_clock_monitor u_monitor (
    .clock_in          (clock_in),
    .sys_rst_in        (sys_rst_in),
    .pixel_clk_in      (pixel_clk_in),
    .pixel_edge_out    (pixel_edge),
    .clock_stopped_out (clock_stopped)
  );

  // the third stage holds the bus as it stood just before the pixel edge,
  // since the edge itself is seen two stages late and hold is short
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      in1_q  <= '0;
      in2_q  <= '0;
      in3_q  <= '0;
      cfg1_q <= 2'h0;
      cfg2_q <= 2'h0;
    end
    else
    begin
      in1_q  <= {color_in, vertical_sync_in, horizontal_sync_in, pixel_valid_in};
      in2_q  <= in1_q;
      in3_q  <= in2_q;
      cfg1_q <= {dither_en_in, width_24_in};
      cfg2_q <= cfg1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    if (cfg2_q[1])
      mode_req = MODE_DITHER;
    else if (cfg2_q[0])
      mode_req = MODE_24;
    else
      mode_req = MODE_18;
    lock_done = (lock_q == LOCK_LAST);
    load      = pixel_edge && (phase_q == PHASE_ACTIVE);
    payload   = build_payload(mode_req, in3_q[IN_W-1:3], in3_q[2], in3_q[1], in3_q[0],
                              fseq_q);
    phase_d     = phase_q;
    mode_d      = mode_q;
    lock_d      = lock_q;
    fseq_d      = fseq_q;
    shift_d     = shift_q;
    bits_left_d = bits_left_q;
    div_d       = div_q;
    clk_lvl_d   = clk_lvl_q;
    bit_d       = bit_q;
    if (pixel_edge)
      mode_d = mode_req;
    case (phase_q)
      PHASE_OFF:
      begin
        if (!clock_stopped)
          phase_d = PHASE_STARTUP;
      end
      PHASE_STARTUP:
      begin
        if (clock_stopped)
          phase_d = PHASE_OFF;
        else if (pixel_edge && lock_done)
          phase_d = PHASE_ACTIVE;
        else if (pixel_edge)
          lock_d = LOCK_W'(lock_q + 1'b1);
      end
      PHASE_ACTIVE:
      begin
        if (clock_stopped)
          phase_d = PHASE_OFF;
        else if (load)
        begin
          // pixel edge restarts the bit grid, so lanes track the pixel rate
          div_d       = '0;
          bit_d       = payload[PAYLOAD_W-1 -: LANE_CNT];
          shift_d     = PAYLOAD_W'(payload << LANE_CNT);
          bits_left_d = ((mode_req == MODE_24) ? LANE_BITS_24 : LANE_BITS_18) - 5'h01;
          fseq_d      = fseq_q + FSEQ_STEP;
          if (div_q == DIV_HALF)
            clk_lvl_d = ~clk_lvl_q;
        end
        else
        begin
          div_d = (div_q == DIV_LAST) ? '0 : DIV_W'(div_q + 1'b1);
          // clock edge sits mid-bit: each bit is launched half a clock
          // phase before the edge that the receiver samples on
          if (div_q == DIV_HALF)
            clk_lvl_d = ~clk_lvl_q;
          if (div_q == DIV_LAST)
          begin
            if (bits_left_q != 5'h00)
            begin
              bit_d       = shift_q[PAYLOAD_W-1 -: LANE_CNT];
              shift_d     = PAYLOAD_W'(shift_q << LANE_CNT);
              bits_left_d = bits_left_q - 5'h01;
            end
            else
              bit_d = '0;
          end
        end
      end
      default:
        phase_d = PHASE_OFF;
    endcase
    if (phase_d == PHASE_OFF)
    begin
      // stop-reset: back to a clean start-up on the next pixel clock
      lock_d      = '0;
      fseq_d      = FSEQ_RESET;
      shift_d     = '0;
      bits_left_d = 5'h00;
      div_d       = '0;
      clk_lvl_d   = 1'b0;
      bit_d       = '0;
    end
    case (phase_q)
      PHASE_ACTIVE:
      begin
        clk_p_d = clk_lvl_q;
        clk_n_d = ~clk_lvl_q;
        dat_p_d = bit_q;
        dat_n_d = ~bit_q;
      end
      PHASE_STARTUP:
      begin
        clk_p_d = 1'b1;
        clk_n_d = 1'b0;
        dat_p_d = '1;
        dat_n_d = '0;
      end
      default:
      begin
        clk_p_d = 1'b0;
        clk_n_d = 1'b0;
        dat_p_d = '0;
        dat_n_d = '0;
      end
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      phase_q               <= PHASE_OFF;
      mode_q                <= MODE_RESET;
      lock_q                <= '0;
      fseq_q                <= FSEQ_RESET;
      shift_q               <= '0;
      bits_left_q           <= 5'h00;
      div_q                 <= '0;
      clk_lvl_q             <= 1'b0;
      bit_q                 <= '0;
      link_clock_lane_p_out <= 1'b0;
      link_clock_lane_n_out <= 1'b0;
      link_data_lane_p_out  <= '0;
      link_data_lane_n_out  <= '0;
    end
    else
    begin
      phase_q               <= phase_d;
      mode_q                <= mode_d;
      lock_q                <= lock_d;
      fseq_q                <= fseq_d;
      shift_q               <= shift_d;
      bits_left_q           <= bits_left_d;
      div_q                 <= div_d;
      clk_lvl_q             <= clk_lvl_d;
      bit_q                 <= bit_d;
      link_clock_lane_p_out <= clk_p_d;
      link_clock_lane_n_out <= clk_n_d;
      link_data_lane_p_out  <= dat_p_d;
      link_data_lane_n_out  <= dat_n_d;
    end
  end

  assign link_phase_out = phase_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence startup_locked_s;
    (phase_q == PHASE_STARTUP) && pixel_edge && lock_done && !clock_stopped;
  endsequence

  sequence enters_active_s;
    (phase_q == PHASE_ACTIVE) && $past(phase_q) == PHASE_STARTUP;
  endsequence

  off_lanes_ground_a: assert property (
    (phase_q == PHASE_OFF) |=> !link_clock_lane_p_out && !link_clock_lane_n_out
      && link_data_lane_p_out == '0 && link_data_lane_n_out == '0)
    else $error("link not at ground while off");

  startup_static_level_a: assert property (
    (phase_q == PHASE_STARTUP) |=> link_clock_lane_p_out && !link_clock_lane_n_out
      && link_data_lane_p_out == '1 && link_data_lane_n_out == '0)
    else $error("link not static during start-up");

  reset_default_mode_a: assert property (
    $fell(sys_rst_in) |-> mode_q == MODE_18 && phase_q == PHASE_OFF)
    else $error("mode not 18-bit after reset");

  mode_on_boundary_a: assert property (
    !pixel_edge |=> $stable(mode_q))
    else $error("mode changed inside a pixel");

  fseq_step_a: assert property (
    load && !clock_stopped |=> fseq_q == 2'($past(fseq_q) + FSEQ_STEP))
    else $error("frame sequence did not step by one");

  stop_resets_link_a: assert property (
    clock_stopped && phase_q != PHASE_OFF |=> phase_q == PHASE_OFF && fseq_q == FSEQ_RESET
      ##1 link_data_lane_p_out == '0)
    else $error("pixel clock stop did not reset the link");

  lock_then_active_a: assert property (
    enters_active_s |-> $past(lock_done) && $past(pixel_edge))
    else $error("active entered before lock");

  locked_goes_active_a: assert property (
    startup_locked_s |=> phase_q == PHASE_ACTIVE
      ##1 link_clock_lane_p_out == $past(clk_lvl_q) && link_clock_lane_n_out == !$past(clk_lvl_q))
    else $error("locked link did not go active");

  payload_parity_odd_a: assert property (
    load |-> ^payload == 1'b1)
    else $error("payload parity not odd");

  legal_phase_step_a: assert property (
    (phase_q == PHASE_OFF) |=> phase_q != PHASE_ACTIVE)
    else $error("off phase jumped straight to active");

  clock_mid_bit_a: assert property (
    $changed(clk_lvl_q) && phase_q == PHASE_ACTIVE |-> $past(div_q) == DIV_HALF)
    else $error("link clock edge not mid-bit");

  lane_bit_count_a: assert property (
    load && !clock_stopped |=> bits_left_q == ((mode_q == MODE_24) ? 5'h0f : 5'h0b))
    else $error("wrong bit count per pixel");

  first_bits_color_a: assert property (
    load && !clock_stopped && mode_req != MODE_DITHER |=> bit_q == $past(in3_q[IN_W-1 -: 2]))
    else $error("payload does not open with colour msbs");

endmodule // rgb_pixel_link_serializer

/* shared/pixel_link_pkg.sv */
package pixel_link_pkg;

  // system clock cycles per serial bit period, and the system clock period in ns
  localparam int          BIT_DIV_DEF     = 2;
  localparam int          CLK_PERIOD_NS   = 40;
  // pixel-clock stop gap that counts as a reset, in pixel periods
  localparam int          STOP_PIXELS     = 4;
  // pll lock time, in pixel periods
  localparam int          LOCK_PIXELS_DEF = 1024;
  localparam int          COLOR_W         = 24;
  localparam int          PAYLOAD_W       = 32;
  localparam int          LANE_CNT        = 2;
  // bits carried on each data lane per pixel
  localparam logic [4:0]  LANE_BITS_18    = 5'h0c;
  localparam logic [4:0]  LANE_BITS_24    = 5'h10;
  localparam logic [1:0]  FSEQ_RESET      = 2'h0;
  localparam logic [1:0]  FSEQ_STEP       = 2'h1;
  localparam logic [1:0]  RESERVED_BITS   = 2'h0;
  localparam logic [7:0]  PAD_18          = 8'h00;

  typedef enum logic [1:0] {
    PHASE_OFF     = 2'b00,
    PHASE_STARTUP = 2'b01,
    PHASE_ACTIVE  = 2'b10
  } phase_t;

  typedef enum logic [1:0] {
    MODE_18     = 2'b00,
    MODE_24     = 2'b01,
    MODE_DITHER = 2'b10
  } mode_t;

  localparam mode_t MODE_RESET = MODE_18;

endpackage

/* tb/link_rx_model.sv */
`timescale 1ns/10ps
module link_rx_model
  import pixel_link_pkg::*;
(
  // serial link from the serializer
  input  wire logic                clk_p_in,
  input  wire logic                clk_n_in,
  input  wire logic [LANE_CNT-1:0] data_p_in,
  input  wire logic [LANE_CNT-1:0] data_n_in,
  // payload format, high for 32 bits
  input  wire logic                wide_in,
  // received payloads
  output logic [31:0]              rx_word_out,
  output int                       rx_count_out,
  output int                       rx_err_out
);
  logic [31:0] sh;
  logic [31:0] w;
  logic [1:0]  f;
  logic        good;
  logic [1:0]  last_f [16];
  int          ok [16];
  int          ph;
  int          lock_ph;

  initial
  begin
    sh = '0;
    rx_word_out = '0;
    rx_count_out = 0;
    rx_err_out = 0;
    ph = 0;
    lock_ph = -1;
  end

  ////////////////////////////////////////
  // sampled just after each clock lane edge, where data sits mid-bit
  always @(clk_p_in or clk_n_in)
  begin
    #1;
    if (clk_p_in === clk_n_in)
    begin
      // link off: framing is lost and found again from the sequence bits
      lock_ph = -1;
      ph = 0;
      foreach (ok[i]) ok[i] = 0;
    end
    else
    begin
      if (data_n_in !== ~data_p_in) rx_err_out++;
      // lane 1 carries the earlier bit of each pair
      sh = {sh[29:0], data_p_in[1], data_p_in[0]};
      ph = (ph + 1) % (wide_in ? 16 : 12);
      w = wide_in ? sh : {sh[23:0], 8'h00};
      f = wide_in ? w[3:2] : w[9:8];
      good = (^w === 1'b1) && (f === last_f[ph] + 2'h1);
      if (lock_ph < 0)
      begin
        ok[ph] = good ? ok[ph] + 1 : 0;
        if (ok[ph] >= 3) lock_ph = ph;
      end
      else if (ph == lock_ph && !good)
      begin
        rx_err_out++;
        lock_ph = -1;
      end
      else if (ph == lock_ph)
      begin
        rx_word_out = w;
        rx_count_out++;
      end
      last_f[ph] = f;
    end
  end
endmodule // link_rx_model

/* tb/test_rgb_pixel_link_serializer.sv */
`timescale 1ns/10ps
module test_rgb_pixel_link_serializer
  import pixel_link_pkg::*;
;
  typedef struct packed {logic [23:0] c; logic vs; logic hs; logic de;} px_t;
  typedef struct packed {logic [31:0] w; logic [31:0] m;} exp_t;

  logic                clock_in = 1'b0;
  logic                sys_rst_in = 1'b1;
  logic                pixel_clk_in = 1'b0;
  logic [COLOR_W-1:0]  color_in = '0;
  logic                vertical_sync_in = 1'b0;
  logic                horizontal_sync_in = 1'b0;
  logic                pixel_valid_in = 1'b0;
  logic                width_24_in = 1'b0;
  logic                dither_en_in = 1'b0;
  logic                clk_p;
  logic                clk_n;
  logic [LANE_CNT-1:0] dat_p;
  logic [LANE_CNT-1:0] dat_n;
  logic [1:0]          link_phase;
  logic [5:0]          lanes;
  wire                 wide = width_24_in && !dither_en_in;
  logic [31:0]         rx_word;
  int                  rx_count;
  int                  rx_err;
  int                  n_mismatch = 0;
  int                  comparisons = 0;
  int                  link_edges = 0;
  int                  pix_half = 480;
  logic                pix_run = 1'b0;
  px_t                 pix_q [$];
  exp_t                exp_q [$];

  assign lanes = {clk_p, clk_n, dat_p, dat_n};

  rgb_pixel_link_serializer #(.BIT_DIV(BIT_DIV_DEF), .LOCK_PIXELS(4))
    rgb_pixel_link_serializer_inst (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .pixel_clk_in(pixel_clk_in),
    .color_in(color_in), .vertical_sync_in(vertical_sync_in),
    .horizontal_sync_in(horizontal_sync_in), .pixel_valid_in(pixel_valid_in),
    .width_24_in(width_24_in), .dither_en_in(dither_en_in),
    .link_clock_lane_p_out(clk_p), .link_clock_lane_n_out(clk_n),
    .link_data_lane_p_out(dat_p), .link_data_lane_n_out(dat_n),
    .link_phase_out(link_phase));

  link_rx_model link_rx_model_inst (
    .clk_p_in(clk_p), .clk_n_in(clk_n), .data_p_in(dat_p), .data_n_in(dat_n),
    .wide_in(wide), .rx_word_out(rx_word), .rx_count_out(rx_count),
    .rx_err_out(rx_err));

  always #(CLK_PERIOD_NS / 2) clock_in = ~clock_in;
  always @(posedge clk_p) link_edges++;

  // pixel source: off-grid phase, data changes on the falling pixel edge
  initial
  begin
    px_t p;
    #7;
    forever
    begin
      #(pix_half);
      if (pix_run || pixel_clk_in)
      begin
        pixel_clk_in = ~pixel_clk_in;
        if (!pixel_clk_in)
        begin
          p = (pix_q.size() > 0) ? pix_q.pop_front() : '0;
          {color_in, vertical_sync_in, horizontal_sync_in, pixel_valid_in} = p;
        end
      end
    end
  end

  ////////////////////////////////////////
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check_val(input string name, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, e, g);
    end
  endtask

  task automatic check_word(input exp_t e, input logic [31:0] g);
    comparisons++;
    if ((g & e.m) !== (e.w & e.m))
    begin
      n_mismatch++;
      $display("unexpected payload: expected %h seen %h", e.w & e.m, g & e.m);
    end
  endtask

  // blanking payloads (valid low) are skipped, real pixels come in order
  always @(rx_count)
  begin
    exp_t e;
    if (rx_word[wide ? 5 : 11] === 1'b1 && exp_q.size() == 0)
      check_val("spare payload", 32'h0, 32'h1);
    else if (rx_word[wide ? 5 : 11] === 1'b1)
    begin
      e = exp_q.pop_front();
      check_word(e, rx_word);
    end
  end

  function automatic logic [5:0] rnd(input logic [7:0] x);
    logic [9:0] t;
    t = {2'b00, x} + 10'h002;
    return (t[9:8] != 2'b00) ? 6'h3f : t[7:2];
  endfunction

  task automatic send_px(input logic [23:0] c, input logic vs, input logic hs);
    logic [17:0] c18;
    exp_t        e;
    c18 = dither_en_in ? {rnd(c[23:16]), rnd(c[15:8]), rnd(c[7:0])}
                       : {c[23:18], c[15:10], c[7:2]};
    e.w = wide ? {c, vs, hs, 1'b1, 5'h00} : {c18, vs, hs, 1'b1, 11'h000};
    e.m = wide ? 32'hffff_ffe0 : 32'hffff_f800;
    exp_q.push_back(e);
    pix_q.push_back({c, vs, hs, 1'b1});
  endtask

  task automatic send_table;
    logic [23:0] cols [4] = '{24'hfc_0084, 24'h80_7f01, 24'hff_fffe, 24'h84_2106};
    for (int i = 0; i < 4; i++) send_px(cols[i], i[0], i[1]);
  endtask

  ////////////////////////////////////////
  task automatic wait_phase(input logic [1:0] ph, input int limit);
    int i;
    for (i = 0; i < limit && link_phase !== ph; i++) @(negedge clock_in);
    check_val("link phase", {30'h0, ph}, {30'h0, link_phase});
    if (i >= limit) finish_test();
  endtask

  task automatic stream(input int limit);
    int i;
    for (i = 0; i < limit && exp_q.size() > 0; i++) @(negedge clock_in);
    check_val("pending payloads", 32'h0, 32'(exp_q.size()));
    if (i >= limit) finish_test();
  endtask

  task automatic count_edges(input int cyc, input int e);
    int a;
    a = link_edges;
    repeat (cyc) @(negedge clock_in);
    check_val("link clock periods", 32'(e), 32'(link_edges - a));
  endtask

  // pixel clock halted: no reset for three periods less four cycles, off soon after
  task automatic stop_link(input int pc);
    int i;
    pix_run = 1'b0;
    for (i = 0; i < 3 * pc - 4 && link_phase !== PHASE_OFF; i++) @(negedge clock_in);
    check_val("early stop reset", 32'(3 * pc - 4), 32'(i));
    wait_phase(PHASE_OFF, 3 * pc);
    @(negedge clock_in);
    check_val("off lanes", 32'h0, {26'h0, lanes});
  endtask

  ////////////////////////////////////////
  task automatic test_reset;
    repeat (5) @(negedge clock_in);
    check_val("reset lanes", 32'h0, {26'h0, lanes});
    sys_rst_in = 1'b0;
    repeat (10) @(negedge clock_in);
    check_val("idle phase", 32'h0, {30'h0, link_phase});
  endtask

  // straps left at reset values: 18-bit, no dither
  task automatic test_18bit;
    pix_half = 480;
    pix_run = 1'b1;
    wait_phase(PHASE_STARTUP, 60);
    repeat (3)
    begin
      repeat (12) @(negedge clock_in);
      check_val("start-up lanes", 32'h0000_002c, {26'h0, lanes});
    end
    wait_phase(PHASE_ACTIVE, 120);
    check_val("clock pair", {31'h0, ~clk_p}, {31'h0, clk_n});
    count_edges(240, 60);
    send_table();
    stream(240);
    stop_link(24);
  endtask

  task automatic test_24bit;
    width_24_in = 1'b1;
    pix_half = 640;
    pix_run = 1'b1;
    wait_phase(PHASE_ACTIVE, 200);
    // a pause well short of the stop gap must not reset
    pix_run = 1'b0;
    repeat (48) @(negedge clock_in);
    pix_run = 1'b1;
    check_val("phase after pause", 32'(PHASE_ACTIVE), {30'h0, link_phase});
    count_edges(320, 80);
    send_table();
    stream(320);
    stop_link(32);
  endtask

  // rounding to six bits with saturation at the top
  // errors counted only while pixels flow: a halted pixel clock lets the
  // link clock run on without payloads, which breaks framing on purpose
  task automatic test_dither;
    int err0;
    dither_en_in = 1'b1;
    pix_half = 480;
    pix_run = 1'b1;
    wait_phase(PHASE_ACTIVE, 150);
    err0 = rx_err;
    count_edges(240, 60);
    send_table();
    stream(240);
    check_val("link errors", 32'h0, 32'(rx_err - err0));
    stop_link(24);
  endtask

  initial
  begin
    test_reset();
    test_18bit();
    test_24bit();
    test_dither();
    finish_test();
  end
endmodule // test_rgb_pixel_link_serializer
